// file: include/ebws_pkg.sv
package ebws_pkg;
	// ======================================================
	// Widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 24;
	// ======================================================
	// Pull-up register bit positions
	localparam int PUR_PROG_BIT = 8;
	localparam int PUR_DATA_BIT = 9;
	// ======================================================
	// Reset values
	localparam logic DRIVE_RST = 1'b0;
	localparam logic [15:0] PUR_RST = 16'hFFFF;
	localparam logic CTRL_PUD_RST = 1'b0;
	// Strobe low cycles and data hold cycles after strobe rises
	localparam int STROBE_CYC = 2;
	localparam int HOLD_CYC = 1;

	// Access request from the core
	typedef struct packed {
		logic write;
		logic program_space;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ebws_req_t;

	// Pin direction and level for one select pin used as port pin
	typedef struct packed {
		logic gpio_mode;
		logic dir_out;
		logic level;
	} ebws_gpio_t;
endpackage : ebws_pkg

// file: rtl/ebws_top.sv
`timescale 1ns/1ps
module ebws_top (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire ebws_pkg::ebws_req_t req_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	output logic [ebws_pkg::DATA_W-1:0] rdata_o,
	output logic rdata_valid_o,
	input wire logic bus_drive_control_i,
	input wire logic [15:0] port_d_pullup_enable_i,
	input wire logic ctrl_pullup_disable_i,
	input wire ebws_pkg::ebws_gpio_t port_d_pin_eight_i,
	input wire ebws_pkg::ebws_gpio_t port_d_pin_nine_i,
	output logic [1:0] port_d_pins_in_o,
	output logic [ebws_pkg::ADDR_W-1:0] address_pins_o,
	output logic [ebws_pkg::DATA_W-1:0] data_pins_o,
	output logic data_pins_oe_n_o,
	input wire logic [ebws_pkg::DATA_W-1:0] data_pins_i,
	output logic write_strobe_n_o,
	output logic write_strobe_oe_n_o,
	output logic write_strobe_pullup_o,
	output logic read_strobe_n_o,
	output logic read_strobe_oe_n_o,
	output logic program_space_select_n_o,
	output logic program_space_select_oe_n_o,
	output logic program_space_select_pullup_o,
	input wire logic program_space_select_i,
	output logic data_space_select_n_o,
	output logic data_space_select_oe_n_o,
	output logic data_space_select_pullup_o,
	input wire logic data_space_select_i
);
	typedef enum logic [1:0] {S_IDLE, S_STROBE, S_HOLD} ebws_state_t;
	ebws_state_t state_reg;
	logic [1:0] cnt_reg;
	ebws_pkg::ebws_req_t cur_reg;
	logic drive_reg;
	logic [15:0] pur_reg;
	logic ctrl_pud_reg;
	logic wr_n_reg, rd_n_reg, prog_sel_n_reg, data_sel_n_reg, doe_n_reg;
	logic [ebws_pkg::DATA_W-1:0] dout_reg, rdata_reg;
	logic rvalid_reg;
	logic [ebws_pkg::ADDR_W-1:0] addr_reg;
	logic [ebws_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg;
	logic [1:0] gin_s1_reg, gin_s2_reg;
	logic bus_en;

	// ======================================================
	// Configuration capture
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			drive_reg <= ebws_pkg::DRIVE_RST;
			pur_reg <= ebws_pkg::PUR_RST;
			ctrl_pud_reg <= ebws_pkg::CTRL_PUD_RST;
		end else begin
			drive_reg <= bus_drive_control_i;
			pur_reg <= port_d_pullup_enable_i;
			ctrl_pud_reg <= ctrl_pullup_disable_i;
		end
	end

	// Pin input synchronisers
	always_ff @(posedge clk_sys_i) begin
		din_s1_reg <= data_pins_i;
		din_s2_reg <= din_s1_reg;
		gin_s1_reg <= {data_space_select_i, program_space_select_i};
		gin_s2_reg <= gin_s1_reg;
	end

	// ======================================================
	// Access sequencer
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg <= S_IDLE;
			cnt_reg <= 2'h0;
			cur_reg <= '0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (req_valid_i) begin
						cur_reg <= req_i;
						cnt_reg <= 2'(ebws_pkg::STROBE_CYC - 1);
						state_reg <= S_STROBE;
					end
				end
				S_STROBE: begin
					if (cnt_reg == 2'h0) begin
						cnt_reg <= 2'(ebws_pkg::HOLD_CYC - 1);
						state_reg <= S_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 2'h1;
					end
				end
				S_HOLD: begin
					if (cnt_reg == 2'h0) begin
						state_reg <= S_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 2'h1;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// Strobes, selects and data drive
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			prog_sel_n_reg <= 1'b1;
			data_sel_n_reg <= 1'b1;
			doe_n_reg <= 1'b1;
			dout_reg <= 16'h0000;
			addr_reg <= 24'h00_0000;
		end else if (state_reg == S_IDLE && req_valid_i) begin
			wr_n_reg <= ~req_i.write;
			rd_n_reg <= req_i.write;
			prog_sel_n_reg <= ~req_i.program_space;
			data_sel_n_reg <= req_i.program_space;
			doe_n_reg <= ~req_i.write;
			dout_reg <= req_i.wdata;
			addr_reg <= req_i.addr;
		end else if (state_reg == S_STROBE && cnt_reg == 2'h0) begin
			// Strobe rises; data, address, selects still held
			wr_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
		end else if (state_reg == S_HOLD && cnt_reg == 2'h0) begin
			prog_sel_n_reg <= 1'b1;
			data_sel_n_reg <= 1'b1;
			doe_n_reg <= 1'b1;
		end
	end

	// Read capture one edge after strobe rise
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= 1'b0;
			// Synchroniser delay: din_s2 now holds a strobe-low sample
			if (state_reg == S_HOLD && !cur_reg.write
				&& cnt_reg == 2'(ebws_pkg::HOLD_CYC - 1)) begin
				rdata_reg <= din_s2_reg;
				rvalid_reg <= 1'b1;
			end
		end
	end

	// ======================================================
	// Pin drive and pull-ups
	assign bus_en = (state_reg != S_IDLE) | drive_reg;
	assign req_ready_o = (state_reg == S_IDLE);
	assign rdata_o = rdata_reg;
	assign rdata_valid_o = rvalid_reg;
	assign address_pins_o = addr_reg;
	assign data_pins_o = dout_reg;
	assign data_pins_oe_n_o = doe_n_reg;
	assign write_strobe_n_o = wr_n_reg;
	assign read_strobe_n_o = rd_n_reg;
	// Reset disables outputs, pull-ups on
	assign write_strobe_oe_n_o = reset_i | ~bus_en;
	assign read_strobe_oe_n_o = reset_i | ~bus_en;
	assign write_strobe_pullup_o = reset_i | ~ctrl_pud_reg;
	// Select pins: port pin mode or memory select
	always_comb begin
		program_space_select_n_o = prog_sel_n_reg;
		program_space_select_oe_n_o = reset_i | ~bus_en;
		if (port_d_pin_eight_i.gpio_mode) begin
			program_space_select_n_o = port_d_pin_eight_i.level;
			program_space_select_oe_n_o = reset_i | ~port_d_pin_eight_i.dir_out;
		end
		data_space_select_n_o = data_sel_n_reg;
		data_space_select_oe_n_o = reset_i | ~bus_en;
		if (port_d_pin_nine_i.gpio_mode) begin
			data_space_select_n_o = port_d_pin_nine_i.level;
			data_space_select_oe_n_o = reset_i | ~port_d_pin_nine_i.dir_out;
		end
	end
	// Select pin pull-ups, forced on in reset
	assign program_space_select_pullup_o =
		reset_i | pur_reg[ebws_pkg::PUR_PROG_BIT];
	assign data_space_select_pullup_o =
		reset_i | pur_reg[ebws_pkg::PUR_DATA_BIT];
	assign port_d_pins_in_o = gin_s2_reg;

	// ======================================================
	// Checks
	property p_wr_data;
		@(posedge clk_sys_i) disable iff (reset_i)
		!write_strobe_n_o |-> !data_pins_oe_n_o;
	endproperty
	a_wr_data: assert property (p_wr_data)
		else $error("data not driven during write strobe");
	property p_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
		$rose(write_strobe_n_o) |-> !data_pins_oe_n_o && $stable(data_pins_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("write data lost at strobe rise");
	property p_qual;
		@(posedge clk_sys_i) disable iff (reset_i)
		!write_strobe_n_o |-> (program_space_select_n_o != data_sel_n_reg
			|| port_d_pin_eight_i.gpio_mode)
			&& ($past(write_strobe_n_o) || $stable(address_pins_o));
	endproperty
	a_qual: assert property (p_qual)
		else $error("selects not qualified during write");
	property p_idle;
		@(posedge clk_sys_i) disable iff (reset_i)
		(state_reg == S_IDLE && !drive_reg) |-> write_strobe_oe_n_o;
	endproperty
	a_idle: assert property (p_idle)
		else $error("strobe driven on idle bus");
	property p_rst;
		@(posedge clk_sys_i) reset_i |-> write_strobe_oe_n_o
			&& write_strobe_pullup_o && data_space_select_pullup_o;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset pin state wrong");
	property p_ps;
		@(posedge clk_sys_i) disable iff (reset_i)
		(state_reg == S_IDLE && req_valid_i && req_i.program_space)
			|=> !prog_sel_n_reg [*3];
	endproperty
	a_ps: assert property (p_ps)
		else $error("program select missing");
	property p_ds;
		@(posedge clk_sys_i) disable iff (reset_i)
		(state_reg == S_IDLE && req_valid_i && !req_i.program_space)
			|=> !data_sel_n_reg [*3];
	endproperty
	a_ds: assert property (p_ds)
		else $error("data select missing");
	property p_rd;
		@(posedge clk_sys_i) disable iff (reset_i)
		$rose(read_strobe_n_o) |=> rdata_valid_o && data_pins_oe_n_o;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read capture missing");
endmodule : ebws_top

// file: sim/ebws_sram_model.sv
`timescale 1ns/1ps
// ==========
// External static RAM on the far side of the pins
module ebws_sram_model (
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic prog_sel_n_i,
	input wire logic data_sel_n_i,
	input wire logic [23:0] addr_i,
	input wire logic [15:0] d_i,
	output logic [15:0] d_o
);
	logic [15:0] mem [0:255];
	logic [15:0] last;
	wire logic [7:0] idx = {prog_sel_n_i, addr_i[6:0]};
	// Latch write data as the strobe rises, only when selected
	always @(posedge we_n_i) begin
		if (!(prog_sel_n_i && data_sel_n_i)) mem[idx] = d_i;
	end
	// Remember the word just read so a released bus shows its inverse
	always @(posedge oe_n_i) last = mem[idx];
	assign d_o = oe_n_i ? ~last : mem[idx];
endmodule : ebws_sram_model

// file: sim/ebws_top_tb.sv
`timescale 1ns/1ps
// ==========
// Bench for the strobe and select pins
module ebws_top_tb;
	logic clk_sys_i = 1'h0, reset_i = 1'h1, req_valid_i = 1'h0;
	logic drive_bit = 1'h0, ctrl = 1'h0;
	ebws_pkg::ebws_req_t req_i = '0;
	ebws_pkg::ebws_gpio_t pin8 = '0, pin9 = '0;
	logic [15:0] pue = 16'hffff;
	logic [1:0] ext = 2'h3;
	logic [31:0] rs = 32'h0000_c821;
	logic [15:0] sh [0:15];
	logic [23:0] ad [0:15];
	logic [15:0] expq [$];
	int fail_count = 0, samples_checked = 0;
	wire logic [15:0] rdata_o, data_pins_o, sram_d, dpin;
	wire logic [23:0] address_pins_o;
	wire logic [1:0] port_d_pins_in_o;
	wire logic req_ready_o, rdata_valid_o, data_pins_oe_n_o;
	wire logic prog_sel_pin, data_sel_pin;
	wire logic write_strobe_n_o, write_strobe_oe_n_o, write_strobe_pullup_o;
	wire logic read_strobe_n_o, read_strobe_oe_n_o;
	wire logic program_space_select_n_o, program_space_select_oe_n_o;
	wire logic program_space_select_pullup_o, data_space_select_pullup_o;
	wire logic data_space_select_n_o, data_space_select_oe_n_o;
	// Pin levels from the core's output enables
	assign dpin = data_pins_oe_n_o ? sram_d : data_pins_o;
	assign prog_sel_pin = program_space_select_oe_n_o ? ext[0]
		: program_space_select_n_o;
	assign data_sel_pin = data_space_select_oe_n_o ? ext[1]
		: data_space_select_n_o;
	ebws_top u_ebws_top (.clk_sys_i, .reset_i, .req_i, .req_valid_i,
		.req_ready_o, .rdata_o, .rdata_valid_o,
		.bus_drive_control_i(drive_bit),
		.port_d_pullup_enable_i(pue), .ctrl_pullup_disable_i(ctrl),
		.port_d_pin_eight_i(pin8), .port_d_pin_nine_i(pin9),
		.port_d_pins_in_o, .address_pins_o, .data_pins_o, .data_pins_oe_n_o,
		.data_pins_i(dpin), .write_strobe_n_o, .write_strobe_oe_n_o,
		.write_strobe_pullup_o, .read_strobe_n_o, .read_strobe_oe_n_o,
		.program_space_select_n_o, .program_space_select_oe_n_o,
		.program_space_select_pullup_o,
		.program_space_select_i(prog_sel_pin),
		.data_space_select_n_o, .data_space_select_oe_n_o,
		.data_space_select_pullup_o, .data_space_select_i(data_sel_pin));
	ebws_sram_model u_ebws_sram_model (.we_n_i(write_strobe_n_o),
		.oe_n_i(read_strobe_n_o), .prog_sel_n_i(program_space_select_n_o),
		.data_sel_n_i(data_space_select_n_o), .addr_i(address_pins_o),
		.d_i(dpin), .d_o(sram_d));
	// Clock
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	// ==========
	// Helpers
	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	// One access, checked mid-strobe; returns once ready again
	task acc(input logic w, input logic [3:0] i);
		int n;
		n = 0;
		rs = lfsr(rs);
		if (w) begin
			sh[i] = rs[15:0];
			ad[i] = {rs[31:15], 4'h0, i[2:0]};
		end else expq.push_back(sh[i]);
		req_i <= '{w, i[3], ad[i], sh[i]};
		req_valid_i <= 1'h1;
		repeat (2) @(negedge clk_sys_i);
		chk("pins", {!w, w, !i[3], i[3], 3'h0, !w, ad[i]}, {write_strobe_n_o,
			read_strobe_n_o, program_space_select_n_o, data_space_select_n_o,
			write_strobe_oe_n_o, program_space_select_oe_n_o,
			data_space_select_oe_n_o, data_pins_oe_n_o, address_pins_o});
		if (w) chk("wdata", sh[i], data_pins_o);
		while (req_ready_o !== 1'h1 && n < 10) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk("ready", 1'h1, req_ready_o);
	endtask : acc
	// Read data watcher against the oldest note
	always @(negedge clk_sys_i) begin
		if (rdata_valid_o === 1'h1) chk("rdata", expq.pop_front(), rdata_o);
	end
	// Watchdog
	initial begin
		#20000;
		fail_count++;
		close_out();
	end
	// ==========
	// Main sequence
	initial begin
		logic lv8, lv9;
		repeat (5) @(negedge clk_sys_i);
		chk("reset", 8'hff, {write_strobe_oe_n_o, program_space_select_oe_n_o,
			data_space_select_oe_n_o, write_strobe_pullup_o,
			program_space_select_pullup_o, data_space_select_pullup_o,
			write_strobe_n_o, read_strobe_n_o});
		repeat (5) @(negedge clk_sys_i);
		reset_i <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			drive_bit <= k[0];
			for (int i = 0; i < 16; i++) acc(1'h1, i[3:0]);
			for (int i = 15; i >= 0; i--) acc(1'h0, i[3:0]);
			req_valid_i <= 1'h0;
			repeat (3) @(negedge clk_sys_i);
			chk("idle", {{4{!k[0]}}, 3'h7}, {write_strobe_oe_n_o,
				read_strobe_oe_n_o, program_space_select_oe_n_o,
				data_space_select_oe_n_o, write_strobe_n_o | !k[0],
				program_space_select_n_o | !k[0],
				data_space_select_n_o | !k[0]});
		end
		for (int k = 0; k < 8; k++) begin
			rs = lfsr(rs);
			pue <= rs[15:0];
			ctrl <= rs[16];
			repeat (3) @(negedge clk_sys_i);
			chk("pullup", {!rs[16], rs[8], rs[9]}, {write_strobe_pullup_o,
				program_space_select_pullup_o, data_space_select_pullup_o});
		end
		for (int k = 0; k < 4; k++) begin
			rs = lfsr(rs);
			pin8 <= '{1'h1, k[0], rs[0]};
			pin9 <= '{1'h1, !k[0], rs[0]};
			ext <= rs[2:1];
			lv8 = k[0] ? rs[0] : rs[1];
			lv9 = k[0] ? rs[2] : rs[0];
			repeat (4) @(negedge clk_sys_i);
			chk("port", {!k[0], k[0], lv9, lv8}, {program_space_select_oe_n_o,
				data_space_select_oe_n_o, port_d_pins_in_o});
		end
		chk("pending", 0, expq.size());
		close_out();
	end
endmodule : ebws_top_tb
